// ==== sld_driver.sv ====
// Top of the serial latch driver: storage register and open-drain outputs.
`timescale 1ns/1ps
`include "sld_params.svh"

module sld_driver (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link clocks and control pins
  input wire logic shift_clk,
  input wire logic latch_clk,
  input wire logic master_clear_n,
  input wire logic output_enable_n,
  // Serial data
  input wire logic serial_in,
  output logic cascade_out,
  // Open-drain parallel outputs
  input wire logic [`SLD_MSB:0] drain_in,
  output logic [`SLD_MSB:0] drain_out,
  output logic [`SLD_MSB:0] drain_out_oe_n,
  // Status
  output logic [`SLD_MSB:0] load_fault,
  output logic frame_underrun,
  output sld_pkg::sld_frame_state_t frame_state,
  output logic [`SLD_COUNT_WIDTH-1:0] shifts_pending
);

  // ************************************************************
  // Resets
  // ************************************************************
  logic clr_pins_n;
  logic clr_meta_n;
  logic clr_mid_n;
  logic clr_hold_n;
  logic next_clr_meta_n;
  logic next_clr_mid_n;
  logic next_clr_hold_n;
  logic sys_clr_n;
  logic link_rst_n;

  // Master clear acts as an asynchronous reset in both domains.
  assign clr_pins_n = rst_n & master_clear_n;

  // Clear takes hold at once but lets go three system edges later, so no
  // system flop leaves reset close to a clock edge.
  always_comb begin
    next_clr_meta_n = 1'h1;
    next_clr_mid_n = clr_meta_n;
    next_clr_hold_n = clr_mid_n;
  end

  always_ff @(posedge sys_clk or negedge clr_pins_n) begin
    if (!clr_pins_n) begin
      clr_meta_n <= 1'h0;
      clr_mid_n <= 1'h0;
      clr_hold_n <= 1'h0;
    end else begin
      clr_meta_n <= next_clr_meta_n;
      clr_mid_n <= next_clr_mid_n;
      clr_hold_n <= next_clr_hold_n;
    end
  end

  assign sys_clr_n = clr_hold_n;

  // The shift clock is still while the host clears, so the link domain
  // takes the pin reset directly; a shift during release is not defined.
  assign link_rst_n = clr_pins_n;

  // ************************************************************
  // Link domain
  // ************************************************************
  sld_pkg::sld_link_t link;
  logic cascade_link;

  sld_shift_stage u_shift (
    .shift_clk(shift_clk),
    .link_rst_n(link_rst_n),
    .serial_in(serial_in),
    .cascade_out(cascade_link),
    .link(link)
  );

  // The cascade pin is a flop of the link domain itself.
  assign cascade_out = cascade_link;

  // ************************************************************
  // Drive ageing for the fault check
  // ************************************************************
  sld_pkg::sld_word_t oe_age_1;
  sld_pkg::sld_word_t oe_age_2;
  sld_pkg::sld_word_t oe_age_3;
  sld_pkg::sld_word_t oe_age_4;
  sld_pkg::sld_word_t next_oe_age_1;
  sld_pkg::sld_word_t next_oe_age_2;
  sld_pkg::sld_word_t next_oe_age_3;
  sld_pkg::sld_word_t next_oe_age_4;

  // The pin readback trails the drive by the four flops of its
  // synchroniser, so the drive is aged by as many before comparing.
  // Extra delay on the board outside would still show a brief fault.
  always_comb begin
    next_oe_age_1 = drain_out_oe_n;
    next_oe_age_2 = oe_age_1;
    next_oe_age_3 = oe_age_2;
    next_oe_age_4 = oe_age_3;
  end

  always_ff @(posedge sys_clk or negedge sys_clr_n) begin
    if (!sys_clr_n) begin
      oe_age_1 <= `SLD_OE_OFF;
      oe_age_2 <= `SLD_OE_OFF;
      oe_age_3 <= `SLD_OE_OFF;
      oe_age_4 <= `SLD_OE_OFF;
    end else begin
      oe_age_1 <= next_oe_age_1;
      oe_age_2 <= next_oe_age_2;
      oe_age_3 <= next_oe_age_3;
      oe_age_4 <= next_oe_age_4;
    end
  end

  // ************************************************************
  // Crossings and pin synchronisers
  // ************************************************************
  sld_pkg::sld_sync_t latch_sync;
  sld_pkg::sld_sync_t enable_sync;
  sld_pkg::sld_sync_t toggle_sync;
  sld_pkg::sld_sync_t drain_sync [`SLD_MSB:0];
  logic [`SLD_MSB:0] drain_level;
  sld_pkg::sld_word_t fault_seen;
  logic shift_seen;

  // The latch clock and the shift toggle pass equal chains, so an edge
  // shared by both clocks arrives in the same system cycle.
  sld_pin_sync #(
    .RESET_LEVEL(1'h0)
  ) u_latch_sync (
    .sys_clk(sys_clk),
    .clr_n(sys_clr_n),
    .raw(latch_clk),
    .result(latch_sync)
  );

  sld_pin_sync #(
    .RESET_LEVEL(1'h1)
  ) u_enable_sync (
    .sys_clk(sys_clk),
    .clr_n(sys_clr_n),
    .raw(output_enable_n),
    .result(enable_sync)
  );

  sld_pin_sync #(
    .RESET_LEVEL(`SLD_TOGGLE_RESET)
  ) u_toggle_sync (
    .sys_clk(sys_clk),
    .clr_n(sys_clr_n),
    .raw(link.toggle),
    .result(toggle_sync)
  );

  genvar g;
  generate
    for (g = 0; g <= `SLD_MSB; g = g + 1) begin : g_drain
      sld_pin_sync #(
        .RESET_LEVEL(1'h1)
      ) u_drain_sync (
        .sys_clk(sys_clk),
        .clr_n(sys_clr_n),
        .raw(drain_in[g]),
        .result(drain_sync[g])
      );
      assign drain_level[g] = drain_sync[g].level;
      assign fault_seen[g] = ~oe_age_4[g] & drain_level[g];
    end
  endgenerate

  // A toggle change in either direction marks one completed shift.
  assign shift_seen = toggle_sync.rise | toggle_sync.fall;

  // ************************************************************
  // Shadow and storage registers
  // ************************************************************
  sld_pkg::sld_word_t shadow;
  sld_pkg::sld_word_t storage;
  sld_pkg::sld_word_t next_shadow;
  sld_pkg::sld_word_t next_storage;

  // The link word is read only after its toggle settles; it then stays
  // still for a full shift period, which must exceed five system cycles.
  always_comb begin
    next_shadow = shadow;
    next_storage = storage;
    if (shift_seen) begin
      next_shadow = link.word;
    end
    if (latch_sync.rise) begin
      next_storage = shadow;
    end
  end

  always_ff @(posedge sys_clk or negedge sys_clr_n) begin
    if (!sys_clr_n) begin
      shadow <= `SLD_STAGE_RESET;
      storage <= `SLD_STORE_RESET;
    end else begin
      shadow <= next_shadow;
      storage <= next_storage;
    end
  end

  // ************************************************************
  // Open-drain output drivers
  // ************************************************************
  logic [`SLD_MSB:0] next_drain_out;
  logic [`SLD_MSB:0] next_drain_oe_n;
  logic [`SLD_MSB:0] next_load_fault;

  // A pin that is pulled low yet reads high points at a shorted load.
  always_comb begin
    next_drain_out = `SLD_DRIVE_LEVEL;
    next_drain_oe_n = `SLD_OE_OFF;
    next_load_fault = `SLD_FAULT_RESET;
    if (!enable_sync.level) begin
      next_drain_oe_n = ~storage;
    end
    next_load_fault = fault_seen;
  end

  always_ff @(posedge sys_clk or negedge sys_clr_n) begin
    if (!sys_clr_n) begin
      drain_out <= `SLD_DRIVE_LEVEL;
      drain_out_oe_n <= `SLD_OE_OFF;
      load_fault <= `SLD_FAULT_RESET;
    end else begin
      drain_out <= next_drain_out;
      drain_out_oe_n <= next_drain_oe_n;
      load_fault <= next_load_fault;
    end
  end

  // ************************************************************
  // Frame progress monitor
  // ************************************************************
  logic [`SLD_COUNT_WIDTH-1:0] next_shifts_pending;
  sld_pkg::sld_frame_state_t next_frame_state;
  logic next_frame_underrun;

  // A shift in the same cycle as a latch belongs to the next frame.
  always_comb begin
    next_shifts_pending = shifts_pending;
    next_frame_underrun = frame_underrun;
    next_frame_state = frame_state;
    if (latch_sync.rise) begin
      next_frame_underrun = (shifts_pending != `SLD_FRAME_BITS);
      next_shifts_pending = shift_seen ? `SLD_COUNT_ONE : `SLD_COUNT_ZERO;
    end else if (shift_seen && (shifts_pending != `SLD_FRAME_BITS)) begin
      next_shifts_pending = shifts_pending + `SLD_COUNT_ONE;
    end
    case (frame_state)
      sld_pkg::SLD_EMPTY: begin
        if (next_shifts_pending != `SLD_COUNT_ZERO) begin
          next_frame_state = sld_pkg::SLD_FILLING;
        end
      end
      sld_pkg::SLD_FILLING: begin
        if (next_shifts_pending == `SLD_FRAME_BITS) begin
          next_frame_state = sld_pkg::SLD_FULL;
        end else if (next_shifts_pending == `SLD_COUNT_ZERO) begin
          next_frame_state = sld_pkg::SLD_EMPTY;
        end
      end
      sld_pkg::SLD_FULL: begin
        if (next_shifts_pending == `SLD_COUNT_ZERO) begin
          next_frame_state = sld_pkg::SLD_EMPTY;
        end else if (next_shifts_pending != `SLD_FRAME_BITS) begin
          next_frame_state = sld_pkg::SLD_FILLING;
        end
      end
      default: begin
        next_frame_state = sld_pkg::SLD_EMPTY;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge sys_clr_n) begin
    if (!sys_clr_n) begin
      shifts_pending <= `SLD_COUNT_ZERO;
      frame_underrun <= 1'h0;
      frame_state <= sld_pkg::SLD_EMPTY;
    end else begin
      shifts_pending <= next_shifts_pending;
      frame_underrun <= next_frame_underrun;
      frame_state <= next_frame_state;
    end
  end

endmodule

// ==== sld_driver_asserts.sv ====
// Port-level checks on the serial latch driver.
`timescale 1ns/1ps
`include "sld_params.svh"

module sld_driver_asserts (
  // Clocks and resets
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic shift_clk,
  input wire logic master_clear_n,
  // Pins and status
  input wire logic latch_clk,
  input wire logic output_enable_n,
  input wire logic serial_in,
  input wire logic cascade_out,
  input wire logic [`SLD_MSB:0] drain_out,
  input wire logic [`SLD_MSB:0] drain_out_oe_n,
  input wire sld_pkg::sld_frame_state_t frame_state,
  input wire logic [`SLD_COUNT_WIDTH-1:0] shifts_pending
);
  // ************************************************************
  // Helper counters
  // ************************************************************
  logic clr_n;
  logic [3:0] shifts_seen;
  logic [3:0] quiet;
  logic [1:0] pins_q;
  assign clr_n = rst_n & master_clear_n;
  // A cascade check is only fair once eight shifts follow a clear.
  always_ff @(posedge shift_clk or negedge clr_n) begin
    if (!clr_n) begin
      shifts_seen <= 4'h0;
    end else begin
      shifts_seen <= (shifts_seen == 4'h8) ? 4'h8 : shifts_seen + 4'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge clr_n) begin
    if (!clr_n) begin
      pins_q <= 2'h3;
      quiet <= 4'h0;
    end else begin
      pins_q <= {latch_clk, output_enable_n};
      quiet <= (pins_q != {latch_clk, output_enable_n}) ? 4'h0 :
               (quiet == 4'hF) ? 4'hF : quiet + 4'h1;
    end
  end

  AST_DRAIN_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    drain_out == 8'h00) else $error("drain data not low");
  AST_OE_OFF: assert property (@(posedge sys_clk) disable iff (!clr_n)
    output_enable_n [*7] |-> drain_out_oe_n == 8'hFF) else $error("outputs not off");
  AST_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !master_clear_n |-> drain_out_oe_n == 8'hFF && shifts_pending == 4'h0 && !cascade_out)
    else $error("clear not applied");
  AST_CASCADE: assert property (@(posedge shift_clk) disable iff (!clr_n)
    shifts_seen == 4'h8 |-> cascade_out == $past(serial_in, 8)) else $error("cascade wrong");
  AST_FULL: assert property (@(posedge sys_clk) disable iff (!clr_n)
    (shifts_pending == 4'h8) == (frame_state == sld_pkg::SLD_FULL)) else $error("full wrong");
  AST_EMPTY: assert property (@(posedge sys_clk) disable iff (!clr_n)
    (shifts_pending == 4'h0) == (frame_state == sld_pkg::SLD_EMPTY)) else $error("empty wrong");
  AST_LATCH: assert property (@(posedge sys_clk) disable iff (!clr_n)
    $rose(latch_clk) |-> ##[4:8] shifts_pending <= 4'h1) else $error("latch not taken");
  AST_QUIET: assert property (@(posedge sys_clk) disable iff (!clr_n)
    $changed(drain_out_oe_n) |-> quiet < 4'h9) else $error("outputs changed unprompted");

  AST_CV_LATCH: cover property (@(posedge sys_clk) $rose(latch_clk) && !output_enable_n);
  AST_CV_SHARED: cover property (@(posedge sys_clk) $rose(latch_clk) && $rose(shift_clk));
  AST_CV_FULL: cover property (@(posedge sys_clk) frame_state == sld_pkg::SLD_FULL);
endmodule

// ==== sld_driver_test.sv ====
// Self-checking bench for the serial latch driver.
`timescale 1ns/1ps
`include "sld_params.svh"

module sld_driver_test;
  logic sys_clk;
  logic rst_n;
  logic master_clear_n;
  logic output_enable_n;
  logic shift_clk, latch_clk, serial_in, cascade_out, frame_underrun;
  logic [7:0] drain_in, drain_out, drain_out_oe_n, load_fault;
  sld_pkg::sld_frame_state_t frame_state;
  logic [3:0] shifts_pending;
  logic [7:0] short_mask;
  int miscompares = 0;
  int compares = 0;

  sld_host_model u_host (.shift_clk(shift_clk), .latch_clk(latch_clk), .serial_in(serial_in));
  sld_driver u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .shift_clk(shift_clk),
    .latch_clk(latch_clk), .master_clear_n(master_clear_n), .output_enable_n(output_enable_n),
    .serial_in(serial_in), .cascade_out(cascade_out), .drain_in(drain_in),
    .drain_out(drain_out), .drain_out_oe_n(drain_out_oe_n), .load_fault(load_fault),
    .frame_underrun(frame_underrun), .frame_state(frame_state),
    .shifts_pending(shifts_pending));

  // Pull-ups: a pin reads high unless its transistor is on, or its load is shorted.
  assign drain_in = drain_out_oe_n | drain_out | short_mask;

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic t_load();
    u_host.send_byte(8'hA5);
    @(negedge sys_clk);
    check("cascade", 8'h01, {7'h00, cascade_out});
    check("pending", 8'h08, {4'h0, shifts_pending});
    check("state", 8'h04, {5'h00, frame_state});
    u_host.latch_pulse();
    @(negedge sys_clk);
    check("drive", ~8'hA5, drain_out_oe_n);
    check("fault", 8'h00, load_fault);
    check("underrun", 8'h00, {7'h00, frame_underrun});
  endtask

  task automatic t_enable();
    output_enable_n = 1'h1;
    repeat (8) @(negedge sys_clk);
    check("off", 8'hFF, drain_out_oe_n);
    output_enable_n = 1'h0;
    repeat (8) @(negedge sys_clk);
    check("back", ~8'hA5, drain_out_oe_n);
  endtask

  // Tied clocks: the storage must take the contents from before the shift.
  task automatic t_shared();
    u_host.send_byte(8'h5A);
    u_host.shift_bit(1'h1, 1'h1);
    repeat (4) @(negedge sys_clk);
    check("tied", ~8'h5A, drain_out_oe_n);
    check("cascade", 8'h01, {7'h00, cascade_out});
    u_host.latch_pulse();
    @(negedge sys_clk);
    check("shifted", ~8'hB5, drain_out_oe_n);
    check("short_frame", 8'h01, {7'h00, frame_underrun});
    check("empty", 8'h01, {5'h00, frame_state});
  endtask

  // A shorted load reads high while driven; a released pin must not count.
  task automatic t_fault();
    short_mask = 8'h03;
    repeat (8) @(negedge sys_clk);
    check("short", 8'h01, load_fault);
    short_mask = 8'h00;
    repeat (8) @(negedge sys_clk);
    check("unshort", 8'h00, load_fault);
  endtask

  task automatic t_clear();
    master_clear_n = 1'h0;
    #1;
    check("clr_drive", 8'hFF, drain_out_oe_n);
    check("clr_cascade", 8'h00, {7'h00, cascade_out});
    @(negedge sys_clk);
    master_clear_n = 1'h1;
    repeat (8) @(negedge sys_clk);
    check("clr_store", 8'hFF, drain_out_oe_n);
    u_host.latch_pulse();
    @(negedge sys_clk);
    check("clr_shift", 8'hFF, drain_out_oe_n);
    u_host.shift_bit(1'h1, 1'h0);
    u_host.latch_pulse();
    @(negedge sys_clk);
    check("clr_stage", 8'hFE, drain_out_oe_n);
    check("clr_tail", 8'h00, {7'h00, cascade_out});
  endtask

  initial begin
    rst_n = 1'h0;
    master_clear_n = 1'h1;
    output_enable_n = 1'h0;
    short_mask = 8'h00;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'h1;
    repeat (4) @(negedge sys_clk);
    t_load();
    t_enable();
    t_shared();
    t_fault();
    t_clear();
    wrap_up();
  end

  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule

bind sld_driver sld_driver_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .shift_clk(shift_clk), .master_clear_n(master_clear_n), .latch_clk(latch_clk),
  .output_enable_n(output_enable_n), .serial_in(serial_in), .cascade_out(cascade_out),
  .drain_out(drain_out), .drain_out_oe_n(drain_out_oe_n), .frame_state(frame_state),
  .shifts_pending(shifts_pending));

// ==== sld_host_model.sv ====
// Host model driving serial data, the shift clock and the latch clock.
`timescale 1ns/1ps

module sld_host_model (
  // Link pins towards the device
  output logic shift_clk,
  output logic latch_clk,
  output logic serial_in
);
  initial begin
    shift_clk = 1'h0;
    latch_clk = 1'h0;
    serial_in = 1'h0;
  end

  // The shift clock stands still between frames, so idle time shows no edges.
  task automatic shift_bit(input logic bit_val, input logic tied);
    serial_in = bit_val;
    #62.5;
    shift_clk = 1'h1;
    if (tied) begin
      latch_clk = 1'h1;
    end
    #62.5;
    shift_clk = 1'h0;
    if (tied) begin
      latch_clk = 1'h0;
    end
  endtask

  task automatic send_byte(input logic [7:0] value);
    for (int i = 7; i >= 0; i--) begin
      shift_bit(value[i], 1'h0);
    end
  endtask

  task automatic latch_pulse();
    latch_clk = 1'h1;
    #62.5;
    latch_clk = 1'h0;
    #62.5;
  endtask
endmodule

// ==== sld_params.svh ====
// Constants for the serial latch driver: widths, reset values and frame counts.
`ifndef SLD_PARAMS_SVH
`define SLD_PARAMS_SVH

// ************************************************************
// Data widths
// ************************************************************
`define SLD_WIDTH 8
`define SLD_MSB 7

// ************************************************************
// Reset values and fixed pin levels
// ************************************************************
`define SLD_STAGE_RESET 8'h00
`define SLD_STORE_RESET 8'h00
`define SLD_DRIVE_LEVEL 8'h00
`define SLD_OE_OFF 8'hFF
`define SLD_FAULT_RESET 8'h00
`define SLD_TOGGLE_RESET 1'h0
`define SLD_CASCADE_RESET 1'h0

// ************************************************************
// Frame counting
// ************************************************************
`define SLD_COUNT_WIDTH 4
`define SLD_FRAME_BITS 4'h8
`define SLD_COUNT_ONE 4'h1
`define SLD_COUNT_ZERO 4'h0

`endif

// ==== sld_pin_sync.sv ====
// Three-stage synchroniser with agreement filter and edge pulses.
`timescale 1ns/1ps
`include "sld_params.svh"

module sld_pin_sync #(
  parameter logic RESET_LEVEL = 1'h0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic clr_n,
  // Raw input and filtered result
  input wire logic raw,
  output sld_pkg::sld_sync_t result
);

  // ************************************************************
  // Sampling chain
  // ************************************************************
  logic meta;
  logic stage_b;
  logic stage_c;
  logic level;
  logic rise;
  logic fall;
  logic next_level;
  logic next_rise;
  logic next_fall;

  // The first flop is only ever read by the second.
  always_comb begin
    next_level = level;
    next_rise = 1'h0;
    next_fall = 1'h0;
    if ((stage_b == stage_c) && (stage_c != level)) begin
      next_level = stage_c;
      next_rise = stage_c;
      next_fall = ~stage_c;
    end
  end

  always_ff @(posedge sys_clk or negedge clr_n) begin
    if (!clr_n) begin
      meta <= RESET_LEVEL;
      stage_b <= RESET_LEVEL;
      stage_c <= RESET_LEVEL;
      level <= RESET_LEVEL;
      rise <= 1'h0;
      fall <= 1'h0;
    end else begin
      meta <= raw;
      stage_b <= meta;
      stage_c <= stage_b;
      level <= next_level;
      rise <= next_rise;
      fall <= next_fall;
    end
  end

  assign result = {level, rise, fall};

endmodule

// ==== sld_pkg.sv ====
// Types shared by the serial latch driver modules.
`include "sld_params.svh"

package sld_pkg;

  // ************************************************************
  // Data words
  // ************************************************************
  typedef logic [`SLD_MSB:0] sld_word_t;

  // Shift contents published from the link domain, qualified by a toggle.
  typedef struct packed {
    sld_word_t word;
    logic toggle;
  } sld_link_t;

  // Result of a synchronised input.
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } sld_sync_t;

  // ************************************************************
  // Frame progress states
  // ************************************************************
  typedef enum logic [2:0] {
    SLD_EMPTY = 3'h1,
    SLD_FILLING = 3'h2,
    SLD_FULL = 3'h4
  } sld_frame_state_t;

endpackage

// ==== sld_shift_stage.sv ====
// Shift register and cascade output running on the shift clock.
`timescale 1ns/1ps
`include "sld_params.svh"

module sld_shift_stage (
  // Link clock and reset
  input wire logic shift_clk,
  input wire logic link_rst_n,
  // Serial data
  input wire logic serial_in,
  output logic cascade_out,
  // Published contents
  output sld_pkg::sld_link_t link
);

  // ************************************************************
  // Shift stages
  // ************************************************************
  sld_pkg::sld_word_t stage;
  sld_pkg::sld_word_t next_stage;
  logic toggle;
  logic next_toggle;
  logic next_cascade;

  always_comb begin
    next_stage = {stage[`SLD_MSB-1:0], serial_in};
    next_cascade = next_stage[`SLD_MSB];
    next_toggle = ~toggle;
  end

  // Each shift flips the toggle; the word stays still for a whole shift period.
  always_ff @(posedge shift_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      stage <= `SLD_STAGE_RESET;
      cascade_out <= `SLD_CASCADE_RESET;
      toggle <= `SLD_TOGGLE_RESET;
    end else begin
      stage <= next_stage;
      cascade_out <= next_cascade;
      toggle <= next_toggle;
    end
  end

  assign link = {stage, toggle};

endmodule
